//--- src/nspc_consts.vh
`ifndef NSPC_CONSTS_VH
`define NSPC_CONSTS_VH

`define NSPC_OFF_CTRL 8'h00
`define NSPC_OFF_ADRL 8'h04
`define NSPC_OFF_ADRH 8'h08
`define NSPC_OFF_DATL 8'h0C
`define NSPC_OFF_DATH 8'h10
`define NSPC_OFF_KEY 8'h14
`define NSPC_OFF_STAT 8'h18

`define NSPC_B_RD 0
`define NSPC_B_WR 1
`define NSPC_B_WEN 2
`define NSPC_B_ERR 3
`define NSPC_B_LOAD 4
`define NSPC_B_ERASE 5
`define NSPC_B_SEL 6
`define NSPC_B_DONE 7
`define NSPC_B_DONEIE 8

`define NSPC_KEY1 8'h55
`define NSPC_KEY2 8'hAA

`define NSPC_OP_READ 3'h0
`define NSPC_OP_ERASE 3'h1
`define NSPC_OP_PROG 3'h2
`define NSPC_OP_EEWR 3'h3
`define NSPC_OP_BULK 3'h4

`define NSPC_PG_READ 2'h0
`define NSPC_PG_WRITE 2'h1
`define NSPC_PG_BULK 2'h2

`define NSPC_EE_BASE 15'h7000
`define NSPC_EE_TOP 15'h70FF
`define NSPC_UID_LAST 15'h0003
`define NSPC_WP_BOOT_END 15'h0200
`define NSPC_WP_HALF_END 15'h1000
`define NSPC_ROW_LAST 6'h3F
`define NSPC_ERASED 14'h3FFF

`define NSPC_CLK_MHZ 10
`define NSPC_T_ERASE_US 2000
`define NSPC_T_PROG_US 2000
`define NSPC_T_EE_US 4000
`define NSPC_T_BULK_US 5000

`endif

//--- src/nspc_ctrl.v
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "nspc_consts.vh"

// What this block does
// - Code protect blocks programmer access; self-write unaffected.
// - Only programmer bulk erase clears code protect, wiping all.
// - Write protect refuses self-write and erase; programmer free.
// - Erase sets all ones; programming only clears bits.
// - Rows of 64 14-bit words; a row is the erase unit.
// - Hidden 14-bit latches load only through the data pair.
// - Unprogrammed words program without a row erase.
// - Self-programming: row writes and row erase, no bulk erase.
// - 256-byte EEPROM written one location at a time.
// - Indirect read: one cycle, CPU stalled, one byte back.
// - Indirect writes and erases are never performed.
// - Register path writes user space and ID words 0 to 3; other config read only.
// - Register writes to protected targets are suppressed.
// - Read strobe stalls CPU; data pair filled next cycle.
// - Data pair holds until another read or software write.
// - Hardware clears the read strobe after the read.
// - Erase, latch load and commit need an unbroken unlock.
// - Unlock: key 55h, key AAh, then write strobe.
// - Flash write and erase strobes stall the processor until done.
// - An internal timer times every write and erase.
// - EEPROM done clears strobe, sets done flag, may interrupt.
// - Row erase on protected flash clears strobe, no erase.
module nspc_ctrl #(
    parameter [15:0] ERASE_CYCLES = `NSPC_T_ERASE_US * `NSPC_CLK_MHZ,
    parameter [15:0] PROG_CYCLES = `NSPC_T_PROG_US * `NSPC_CLK_MHZ,
    parameter [15:0] EE_CYCLES = `NSPC_T_EE_US * `NSPC_CLK_MHZ,
    parameter [15:0] BULK_CYCLES = `NSPC_T_BULK_US * `NSPC_CLK_MHZ
) (
    // Clock, reset, enable
    input wire clk_sys_in,
    input wire reset_in,
    input wire ce_in,
    // APB slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    output wire [31:0] prdata_out,
    output wire pready_out,
    output wire pslverr_out,
    // CPU side
    output wire cpu_stall_out,
    output wire nvm_irq_out,
    // Indirect pointer port
    input wire ind_req_in,
    input wire ind_write_in,
    input wire [15:0] ind_addr_in,
    output wire [7:0] ind_rdata_out,
    output wire ind_done_out,
    // Configuration word bits
    input wire cfg_program_code_protect_in,
    input wire cfg_eeprom_code_protect_in,
    input wire [1:0] cfg_write_protect_range_in,
    // External programmer port
    input wire pgm_req_in,
    input wire [1:0] pgm_op_in,
    input wire pgm_region_in,
    input wire [14:0] pgm_addr_in,
    input wire [13:0] pgm_wdata_in,
    output wire [13:0] pgm_rdata_out,
    output wire pgm_done_out,
    output wire pgm_denied_out,
    // Memory array port
    output wire arr_cmd_out,
    output wire [2:0] arr_op_out,
    output wire arr_region_out,
    output wire [14:0] arr_addr_out,
    output wire [13:0] arr_wdata_out,
    input wire [13:0] arr_rdata_in
);
    localparam [1:0] S_IDLE = 2'd0;
    localparam [1:0] S_READ = 2'd1;
    localparam [1:0] S_STREAM = 2'd2;
    localparam [1:0] S_WAIT = 2'd3;
    localparam [1:0] SRC_SW = 2'd0;
    localparam [1:0] SRC_IND = 2'd1;
    localparam [1:0] SRC_PGM = 2'd2;

    reg [1:0] state_q, src_q, key_q, wrt_q;
    reg [14:0] adr_q, arr_addr_q;
    reg [13:0] dat_q, pgm_rdata_q, arr_wdata_q, lat_data_q;
    reg rd_q, wr_q, wen_q, err_q, load_q, erase_q, sel_q, done_q, doneie_q;
    reg cp_q, cpd_q, cfg_loaded_q, hold_q, stall_q, irq_q, pready_q, pslverr_q;
    reg ind_done_q, pgm_done_q, pgm_denied_q, arr_cmd_q, arr_region_q, tmr_load_q, lat_wr_q, lat_fill_q;
    reg [5:0] idx_q, lat_idx_q;
    reg [31:0] prdata_q, rmux_w;
    reg [7:0] ind_rdata_q;
    reg [2:0] arr_op_q;
    reg [15:0] tmr_cycles_q;
    reg wp_w, mapped_w;
    wire tmr_done_w;
    wire [13:0] lat_rd_w;

    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign cpu_stall_out = stall_q;
    assign nvm_irq_out = irq_q;
    assign ind_rdata_out = ind_rdata_q;
    assign ind_done_out = ind_done_q;
    assign pgm_rdata_out = pgm_rdata_q;
    assign pgm_done_out = pgm_done_q;
    assign pgm_denied_out = pgm_denied_q;
    assign arr_cmd_out = arr_cmd_q;
    assign arr_op_out = arr_op_q;
    assign arr_region_out = arr_region_q;
    assign arr_addr_out = arr_addr_q;
    assign arr_wdata_out = arr_wdata_q;

    wire wr_w = psel_in & penable_in & pready_q & pwrite_in;
    wire ctrl_w = wr_w & (paddr_in == `NSPC_OFF_CTRL);
    wire idle_w = (state_q == S_IDLE) & cfg_loaded_q;
    wire sel_w = pwdata_in[`NSPC_B_SEL];
    wire go_w = ctrl_w & idle_w & pwdata_in[`NSPC_B_WR];
    wire rdgo_w = ctrl_w & idle_w & pwdata_in[`NSPC_B_RD] & ~pwdata_in[`NSPC_B_WR];
    wire unlocked_w = (key_q == 2'd2) & pwdata_in[`NSPC_B_WEN];
    wire ee_w = sel_w & (adr_q >= `NSPC_EE_BASE) & (adr_q <= `NSPC_EE_TOP);
    wire uid_w = sel_w & (adr_q <= `NSPC_UID_LAST);
    wire pgm_ee_w = pgm_region_in & (pgm_addr_in >= `NSPC_EE_BASE) & (pgm_addr_in <= `NSPC_EE_TOP);
    wire pgm_deny_w = (pgm_op_in != `NSPC_PG_BULK) & ((~pgm_region_in & cp_q) | (pgm_ee_w & cpd_q));
    wire ext_ok_w = idle_w & ~hold_q & ~go_w & ~rdgo_w;

    always @* begin
        case (wrt_q)
            2'd0: wp_w = 1'b1;
            2'd1: wp_w = adr_q < `NSPC_WP_HALF_END;
            2'd2: wp_w = adr_q < `NSPC_WP_BOOT_END;
            default: wp_w = 1'b0;
        endcase
    end

    always @* begin
        mapped_w = 1'b1;
        rmux_w = 32'h0000_0000;
        case (paddr_in)
            `NSPC_OFF_CTRL: rmux_w = {23'h00_0000, doneie_q, done_q, sel_q, erase_q, load_q, err_q, wen_q, wr_q, rd_q};
            `NSPC_OFF_ADRL: rmux_w = {24'h00_0000, adr_q[7:0]};
            `NSPC_OFF_ADRH: rmux_w = {25'h000_0000, adr_q[14:8]};
            `NSPC_OFF_DATL: rmux_w = {24'h00_0000, dat_q[7:0]};
            `NSPC_OFF_DATH: rmux_w = {26'h000_0000, dat_q[13:8]};
            `NSPC_OFF_KEY: rmux_w = 32'h0000_0000;
            `NSPC_OFF_STAT: rmux_w = {24'h00_0000, state_q, key_q, wrt_q, cpd_q, cp_q};
            default: mapped_w = 1'b0;
        endcase
    end

    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            state_q <= S_IDLE;
            src_q <= SRC_SW;
            adr_q <= 15'h0000;
            dat_q <= 14'h0000;
            {rd_q, wr_q, wen_q, err_q, load_q, erase_q, sel_q, done_q, doneie_q} <= 9'h000;
            {cp_q, cpd_q, cfg_loaded_q, hold_q, stall_q, irq_q, pready_q, pslverr_q} <= 8'h00;
            {ind_done_q, pgm_done_q, pgm_denied_q, arr_cmd_q, arr_region_q, tmr_load_q, lat_wr_q, lat_fill_q} <= 8'h00;
            key_q <= 2'd0;
            wrt_q <= 2'd3;
            idx_q <= 6'h00;
            prdata_q <= 32'h0000_0000;
            ind_rdata_q <= 8'h00;
            pgm_rdata_q <= 14'h0000;
            arr_op_q <= `NSPC_OP_READ;
            arr_addr_q <= 15'h0000;
            arr_wdata_q <= 14'h0000;
            tmr_cycles_q <= 16'h0000;
            lat_idx_q <= 6'h00;
            lat_data_q <= 14'h0000;
        end else if (ce_in) begin
            {arr_cmd_q, ind_done_q, pgm_done_q, pgm_denied_q, tmr_load_q, lat_wr_q, lat_fill_q, hold_q} <= 8'h00;
            irq_q <= done_q & doneie_q;
            // One wait state: answer prepared in the first access cycle
            pready_q <= psel_in & penable_in & ~pready_q;
            pslverr_q <= psel_in & penable_in & ~pready_q & ~mapped_w;
            if (psel_in & penable_in & ~pready_q) begin
                prdata_q <= rmux_w;
            end
            if (!cfg_loaded_q) begin
                cp_q <= cfg_program_code_protect_in;
                cpd_q <= cfg_eeprom_code_protect_in;
                wrt_q <= cfg_write_protect_range_in;
                cfg_loaded_q <= 1'b1;
            end
            if (wr_w) begin
                if (paddr_in == `NSPC_OFF_KEY && pwdata_in[7:0] == `NSPC_KEY1) begin
                    key_q <= 2'd1;
                end else if (paddr_in == `NSPC_OFF_KEY && pwdata_in[7:0] == `NSPC_KEY2 && key_q == 2'd1) begin
                    key_q <= 2'd2;
                end else begin
                    key_q <= 2'd0;
                end
            end
            if (ctrl_w) begin
                doneie_q <= pwdata_in[`NSPC_B_DONEIE];
                done_q <= pwdata_in[`NSPC_B_DONE];
            end
            if (wr_w & idle_w) begin
                case (paddr_in)
                    `NSPC_OFF_ADRL: adr_q[7:0] <= pwdata_in[7:0];
                    `NSPC_OFF_ADRH: adr_q[14:8] <= pwdata_in[6:0];
                    `NSPC_OFF_DATL: dat_q[7:0] <= pwdata_in[7:0];
                    `NSPC_OFF_DATH: dat_q[13:8] <= pwdata_in[5:0];
                    `NSPC_OFF_CTRL: begin
                        wen_q <= pwdata_in[`NSPC_B_WEN];
                        err_q <= pwdata_in[`NSPC_B_ERR];
                        load_q <= pwdata_in[`NSPC_B_LOAD];
                        erase_q <= pwdata_in[`NSPC_B_ERASE];
                        sel_q <= sel_w;
                    end
                    default: sel_q <= sel_q;
                endcase
            end
            case (state_q)
                S_IDLE: begin
                    if (rdgo_w) begin
                        rd_q <= 1'b1;
                        stall_q <= 1'b1;
                        arr_cmd_q <= 1'b1;
                        arr_op_q <= `NSPC_OP_READ;
                        arr_region_q <= sel_w;
                        arr_addr_q <= adr_q;
                        src_q <= SRC_SW;
                        state_q <= S_READ;
                    end else if (go_w & unlocked_w) begin
                        src_q <= SRC_SW;
                        arr_region_q <= sel_w;
                        if (pwdata_in[`NSPC_B_ERASE]) begin
                            if ((~sel_w & wp_w) | (sel_w & ~uid_w)) begin
                                err_q <= 1'b1;
                            end else begin
                                wr_q <= 1'b1;
                                stall_q <= 1'b1;
                                arr_cmd_q <= 1'b1;
                                arr_op_q <= `NSPC_OP_ERASE;
                                arr_addr_q <= {adr_q[14:6], 6'h00};
                                tmr_load_q <= 1'b1;
                                tmr_cycles_q <= ERASE_CYCLES;
                                state_q <= S_WAIT;
                            end
                        end else if (pwdata_in[`NSPC_B_LOAD]) begin
                            if (~sel_w | uid_w) begin
                                lat_wr_q <= 1'b1;
                                lat_idx_q <= adr_q[5:0];
                                lat_data_q <= dat_q;
                            end else begin
                                err_q <= 1'b1;
                            end
                        end else if (ee_w) begin
                            // EEPROM runs in the background; CPU keeps going
                            wr_q <= 1'b1;
                            arr_cmd_q <= 1'b1;
                            arr_op_q <= `NSPC_OP_EEWR;
                            arr_addr_q <= adr_q;
                            arr_wdata_q <= {6'h00, dat_q[7:0]};
                            tmr_load_q <= 1'b1;
                            tmr_cycles_q <= EE_CYCLES;
                            state_q <= S_WAIT;
                        end else if ((~sel_w & ~wp_w) | uid_w) begin
                            wr_q <= 1'b1;
                            stall_q <= 1'b1;
                            idx_q <= 6'h00;
                            state_q <= S_STREAM;
                        end else begin
                            err_q <= 1'b1;
                        end
                    end else if (pgm_req_in & ext_ok_w) begin
                        src_q <= SRC_PGM;
                        arr_region_q <= pgm_region_in;
                        arr_addr_q <= pgm_addr_in;
                        arr_wdata_q <= pgm_wdata_in;
                        if (pgm_deny_w) begin
                            pgm_done_q <= 1'b1;
                            pgm_denied_q <= 1'b1;
                            hold_q <= 1'b1;
                        end else if (pgm_op_in == `NSPC_PG_READ) begin
                            arr_cmd_q <= 1'b1;
                            arr_op_q <= `NSPC_OP_READ;
                            state_q <= S_READ;
                        end else if (pgm_op_in == `NSPC_PG_WRITE) begin
                            arr_cmd_q <= 1'b1;
                            arr_op_q <= `NSPC_OP_PROG;
                            tmr_load_q <= 1'b1;
                            tmr_cycles_q <= PROG_CYCLES;
                            state_q <= S_WAIT;
                        end else begin
                            // Bulk erase exists only on this port
                            arr_cmd_q <= 1'b1;
                            arr_op_q <= `NSPC_OP_BULK;
                            cp_q <= 1'b0;
                            cpd_q <= 1'b0;
                            wrt_q <= 2'd3;
                            lat_fill_q <= 1'b1;
                            tmr_load_q <= 1'b1;
                            tmr_cycles_q <= BULK_CYCLES;
                            state_q <= S_WAIT;
                        end
                    end else if (ind_req_in & ext_ok_w) begin
                        hold_q <= ind_write_in;
                        if (ind_write_in) begin
                            ind_done_q <= 1'b1;
                        end else begin
                            stall_q <= 1'b1;
                            arr_cmd_q <= 1'b1;
                            arr_op_q <= `NSPC_OP_READ;
                            arr_region_q <= 1'b0;
                            arr_addr_q <= ind_addr_in[14:0];
                            src_q <= SRC_IND;
                            state_q <= S_READ;
                        end
                    end
                end
                S_READ: begin
                    stall_q <= 1'b0;
                    state_q <= S_IDLE;
                    case (src_q)
                        SRC_SW: begin
                            dat_q <= arr_rdata_in;
                            rd_q <= 1'b0;
                        end
                        SRC_IND: begin
                            ind_rdata_q <= arr_rdata_in[7:0];
                            ind_done_q <= 1'b1;
                            hold_q <= 1'b1;
                        end
                        default: begin
                            pgm_rdata_q <= arr_rdata_in;
                            pgm_done_q <= 1'b1;
                            hold_q <= 1'b1;
                        end
                    endcase
                end
                S_STREAM: begin
                    arr_cmd_q <= 1'b1;
                    arr_op_q <= `NSPC_OP_PROG;
                    arr_addr_q <= {adr_q[14:6], idx_q};
                    arr_wdata_q <= lat_rd_w;
                    idx_q <= idx_q + 6'h01;
                    if (idx_q == `NSPC_ROW_LAST) begin
                        lat_fill_q <= 1'b1;
                        tmr_load_q <= 1'b1;
                        tmr_cycles_q <= PROG_CYCLES;
                        state_q <= S_WAIT;
                    end
                end
                default: begin
                    if (tmr_done_w) begin
                        state_q <= S_IDLE;
                        stall_q <= 1'b0;
                        if (src_q == SRC_PGM) begin
                            pgm_done_q <= 1'b1;
                            hold_q <= 1'b1;
                        end else begin
                            wr_q <= 1'b0;
                            done_q <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    nspc_timer u_tmr (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .load_in(tmr_load_q),
        .cycles_in(tmr_cycles_q),
        .done_out(tmr_done_w)
    );

    nspc_wlatch u_lat (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .wr_in(lat_wr_q),
        .idx_in(lat_idx_q),
        .data_in(lat_data_q),
        .fill_in(lat_fill_q),
        .rd_idx_in(idx_q),
        .rd_data_out(lat_rd_w)
    );
endmodule

//--- src/nspc_timer.v
`timescale 1ns/1ps
`include "nspc_consts.vh"

module nspc_timer (
    // Clock and reset
    input wire clk_sys_in,
    input wire reset_in,
    input wire ce_in,
    // Control
    input wire load_in,
    input wire [15:0] cycles_in,
    output wire done_out
);
    reg [15:0] cnt_q;
    reg done_q;

    assign done_out = done_q;

    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            cnt_q <= 16'h0000;
            done_q <= 1'b0;
        end else if (ce_in) begin
            done_q <= 1'b0;
            if (load_in) begin
                cnt_q <= cycles_in;
            end else if (cnt_q != 16'h0000) begin
                cnt_q <= cnt_q - 16'h0001;
                // Pulse as the last cycle is counted off
                done_q <= (cnt_q == 16'h0001);
            end
        end
    end
endmodule

//--- src/nspc_wlatch.v
`timescale 1ns/1ps
`include "nspc_consts.vh"

module nspc_wlatch (
    // Clock and reset
    input wire clk_sys_in,
    input wire reset_in,
    input wire ce_in,
    // Load port
    input wire wr_in,
    input wire [5:0] idx_in,
    input wire [13:0] data_in,
    input wire fill_in,
    // Read port
    input wire [5:0] rd_idx_in,
    output wire [13:0] rd_data_out
);
    wire [13:0] word_w [0:63];

    genvar gi;
    generate
        for (gi = 0; gi < 64; gi = gi + 1) begin : g_lat
            reg [13:0] lat_q;
            // Refill with erased value so untouched words program nothing
            always @(posedge clk_sys_in) begin
                if (reset_in) begin
                    lat_q <= `NSPC_ERASED;
                end else if (ce_in) begin
                    if (fill_in) begin
                        lat_q <= `NSPC_ERASED;
                    end else if (wr_in && idx_in == gi) begin
                        lat_q <= data_in;
                    end
                end
            end
            assign word_w[gi] = lat_q;
        end
    endgenerate

    assign rd_data_out = word_w[rd_idx_in];
endmodule

//--- tb/nspc_arr_model.sv
`timescale 1ns/1ps
`include "nspc_consts.vh"
module nspc_arr_model (
    input wire clk_sys_in,
    input wire cmd_in,
    input wire [2:0] op_in,
    input wire [14:0] addr_in,
    input wire [13:0] wdata_in,
    output wire [13:0] rdata_out
);
    // One row mirrored over all addresses; enough for row-sized checks
    reg [13:0] mem_q [0:63];
    integer i;
    initial for (i = 0; i < 64; i = i + 1) mem_q[i] = `NSPC_ERASED;
    assign rdata_out = mem_q[addr_in[5:0]];
    always @(posedge clk_sys_in) begin
        if (cmd_in && op_in == `NSPC_OP_ERASE) begin
            for (i = 0; i < 64; i = i + 1) mem_q[i] <= `NSPC_ERASED;
        end
        if (cmd_in && op_in == `NSPC_OP_PROG) begin
            mem_q[addr_in[5:0]] <= mem_q[addr_in[5:0]] & wdata_in;
        end
    end
endmodule

//--- tb/nspc_ctrl_properties.sv
`timescale 1ns/1ps
`include "nspc_consts.vh"
module nspc_ctrl_chk (
    // Clock, reset, APB
    input wire clk_sys_in, input wire reset_in, input wire psel_in, input wire penable_in,
    input wire pwrite_in, input wire [7:0] paddr_in, input wire [31:0] pwdata_in,
    input wire pready_out, input wire pslverr_out, input wire cpu_stall_out,
    // Array, indirect, programmer
    input wire arr_cmd_out, input wire [2:0] arr_op_out, input wire arr_region_out,
    input wire [14:0] arr_addr_out, input wire ind_req_in, input wire ind_done_out,
    input wire pgm_req_in, input wire [1:0] cfg_write_protect_range_in
);
    reg [1:0] key_q;
    reg arm_q;
    wire wr = psel_in && penable_in && pready_out && pwrite_in;
    wire key = wr && paddr_in == `NSPC_OFF_KEY;
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            key_q <= 2'd0;
            arm_q <= 1'b0;
        end else if (wr) begin
            key_q <= (key && pwdata_in[7:0] == `NSPC_KEY1) ? 2'd1 :
                     (key && pwdata_in[7:0] == `NSPC_KEY2 && key_q == 2'd1) ? 2'd2 : 2'd0;
            if (paddr_in == `NSPC_OFF_CTRL && pwdata_in[`NSPC_B_WR]) arm_q <= key_q == 2'd2;
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    property p_wait; psel_in && penable_in && !pready_out |=> pready_out; endproperty
    a_wait: assert property (p_wait) else $error("no ready after one wait");
    property p_err; pslverr_out |-> pready_out; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_unlock; arr_cmd_out && arr_op_out inside {`NSPC_OP_ERASE, `NSPC_OP_PROG, `NSPC_OP_EEWR}
        && !pgm_req_in |-> arm_q; endproperty
    a_unlock: assert property (p_unlock) else $error("write without unlock");
    property p_bulk; arr_cmd_out && arr_op_out == `NSPC_OP_BULK |-> pgm_req_in; endproperty
    a_bulk: assert property (p_bulk) else $error("bulk erase from software");
    property p_row; arr_cmd_out && arr_op_out == `NSPC_OP_ERASE |-> arr_addr_out[5:0] == 6'h00; endproperty
    a_row: assert property (p_row) else $error("erase not row aligned");
    property p_wp; arr_cmd_out && arr_op_out inside {`NSPC_OP_ERASE, `NSPC_OP_PROG} && !arr_region_out
        && !pgm_req_in && cfg_write_protect_range_in == 2'd2 |-> arr_addr_out >= `NSPC_WP_BOOT_END; endproperty
    a_wp: assert property (p_wp) else $error("protected flash written");
    property p_rd; $rose(cpu_stall_out) && arr_cmd_out && arr_op_out == `NSPC_OP_READ |=> !cpu_stall_out;
    endproperty
    a_rd: assert property (p_rd) else $error("read stall too long");
    property p_ind; ind_done_out |-> $past(ind_req_in) && !$past(ind_done_out); endproperty
    a_ind: assert property (p_ind) else $error("indirect done unrequested");
    c_prog: cover property (arr_cmd_out && arr_op_out == `NSPC_OP_PROG);
    c_erase: cover property (arr_cmd_out && arr_op_out == `NSPC_OP_ERASE);
    c_err: cover property (pslverr_out);
endmodule
bind nspc_ctrl nspc_ctrl_chk i_nspc_ctrl_chk (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .cpu_stall_out(cpu_stall_out), .arr_cmd_out(arr_cmd_out), .arr_op_out(arr_op_out),
    .arr_region_out(arr_region_out), .arr_addr_out(arr_addr_out), .ind_req_in(ind_req_in),
    .ind_done_out(ind_done_out), .pgm_req_in(pgm_req_in), .cfg_write_protect_range_in(cfg_write_protect_range_in));

//--- tb/nvm_self_program_control_test.sv
`timescale 1ns/1ps
`include "nspc_consts.vh"
module nvm_self_program_control_test;
    reg clk = 0, rst = 1, ce = 1, psel = 0, pen = 0, pw = 0, ireq = 0, iw = 0, cp = 0, preq = 0, preg = 0, e;
    reg [1:0] wrt = 2'd2, pop = 2'd0;
    reg [7:0] pa = 0;
    reg [31:0] pd = 0, r;
    reg [15:0] ia = 16'h0205;
    reg [14:0] padr = 0;
    reg [13:0] pwd = 0;
    wire [31:0] prd;
    wire prdy, perr, acmd, areg, idone;
    wire [7:0] ird;
    wire [2:0] aop;
    wire [14:0] aad;
    wire [13:0] awd, ard;
    integer num_errors = 0, comparisons = 0, cyc = 0;
    always #50 clk = ~clk;
    nspc_ctrl #(.ERASE_CYCLES(16'd10), .PROG_CYCLES(16'd10), .EE_CYCLES(16'd10), .BULK_CYCLES(16'd10))
    i_nspc_ctrl (.clk_sys_in(clk), .reset_in(rst), .ce_in(ce), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pw), .paddr_in(pa), .pwdata_in(pd), .prdata_out(prd), .pready_out(prdy),
        .pslverr_out(perr), .cpu_stall_out(), .nvm_irq_out(), .ind_req_in(ireq), .ind_write_in(iw),
        .ind_addr_in(ia), .ind_rdata_out(ird), .ind_done_out(idone), .cfg_program_code_protect_in(cp),
        .cfg_eeprom_code_protect_in(cp), .cfg_write_protect_range_in(wrt), .pgm_req_in(preq),
        .pgm_op_in(pop), .pgm_region_in(preg), .pgm_addr_in(padr), .pgm_wdata_in(pwd),
        .pgm_rdata_out(), .pgm_done_out(), .pgm_denied_out(), .arr_cmd_out(acmd), .arr_op_out(aop),
        .arr_region_out(areg), .arr_addr_out(aad), .arr_wdata_out(awd), .arr_rdata_in(ard));
    nspc_arr_model i_nspc_arr_model (.clk_sys_in(clk), .cmd_in(acmd), .op_in(aop), .addr_in(aad),
        .wdata_in(awd), .rdata_out(ard));
    task print_verdict;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors = num_errors + 1;
            print_verdict;
        end
    end
    task chk(input [31:0] g, input [31:0] x);
        comparisons = comparisons + 1;
        if (g !== x) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0t got %h expected %h", $time, g, x);
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        @(posedge clk);
        psel <= 1; pw <= w; pa <= a; pd <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (prdy !== 1'b1);
        r = prd; e = perr;
        psel <= 0; pen <= 0;
    endtask
    // Keys back to back with nothing in between
    task unlock_wr(input [31:0] c);
        apb(1, `NSPC_OFF_KEY, 32'h0000_0055);
        apb(1, `NSPC_OFF_KEY, 32'h0000_00AA);
        apb(1, `NSPC_OFF_CTRL, c);
        do apb(0, `NSPC_OFF_CTRL, 0); while (r[`NSPC_B_WR] !== 1'b0);
    endtask
    task rd(input [14:0] a, input [13:0] x);
        apb(1, `NSPC_OFF_ADRL, {24'h0, a[7:0]});
        apb(1, `NSPC_OFF_ADRH, {25'h0, a[14:8]});
        apb(1, `NSPC_OFF_CTRL, 32'h0000_0001);
        apb(0, `NSPC_OFF_CTRL, 0);
        chk(r[`NSPC_B_RD], 0);
        apb(0, `NSPC_OFF_DATL, 0);
        chk(r[7:0], x[7:0]);
        apb(0, `NSPC_OFF_DATH, 0);
        chk(r[5:0], x[13:8]);
    endtask
    task t_prog;
        apb(1, `NSPC_OFF_DATL, 32'h0000_0034);
        apb(1, `NSPC_OFF_DATH, 32'h0000_0012);
        apb(1, `NSPC_OFF_ADRL, 32'h0000_0005);
        apb(1, `NSPC_OFF_ADRH, 32'h0000_0002);
        unlock_wr(32'h0000_0016);
        unlock_wr(32'h0000_0006);
        chk(r[`NSPC_B_DONE], 1);
        rd(15'h0205, 14'h1234);
        rd(15'h0206, `NSPC_ERASED);
        $display("test prog done");
    endtask
    task t_misc;
        apb(0, 8'h1C, 0);
        chk(e, 1);
        chk(r, 0);
        @(posedge clk);
        ireq <= 1; iw <= 0;
        do @(posedge clk); while (idone !== 1'b1);
        ireq <= 0;
        chk(ird, 8'h34);
        apb(1, `NSPC_OFF_ADRL, 0);
        apb(1, `NSPC_OFF_ADRH, 32'h0000_0070);
        unlock_wr(32'h0000_0046);
        chk(r[`NSPC_B_DONE], 1);
        chk(r[`NSPC_B_WEN], 1);
        $display("test misc done");
    endtask
    task t_locks;
        apb(1, `NSPC_OFF_KEY, 32'h0000_0055);
        apb(1, `NSPC_OFF_DATL, 0);
        apb(1, `NSPC_OFF_KEY, 32'h0000_00AA);
        apb(1, `NSPC_OFF_CTRL, 32'h0000_0026);
        rd(15'h0205, 14'h1234);
        rd(15'h01C0, `NSPC_ERASED);
        unlock_wr(32'h0000_0026);
        chk(r[`NSPC_B_ERR], 1);
        rd(15'h01C5, 14'h1234);
        rd(15'h0200, `NSPC_ERASED);
        unlock_wr(32'h0000_0026);
        rd(15'h0205, `NSPC_ERASED);
        $display("test locks done");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        t_prog;
        t_misc;
        t_locks;
        print_verdict;
    end
endmodule
